// File: core/phb_pkg.sv
package phb_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int ROW_W = 7;
  localparam int RROW_W = ADDR_W - ROW_W;
  localparam int PIN_W = ADDR_W + DATA_W + 8;
  // Control pins idle: clock low, every active-low strobe high, register select low
  localparam logic [7:0] PIN_CTL_RST = 8'h7B;
  localparam logic [1:0] AV_STATUS = 2'h0;
  localparam logic [1:0] AV_TEMP = 2'h1;
  localparam logic [1:0] AV_BCR = 2'h2;
  localparam logic [1:0] AV_RCR = 2'h3;
  localparam int BCR_LEN = 0;
  localparam int BCR_WRAP = 3;
  localparam int BCR_WPOL = 10;
  localparam int BCR_LAT = 11;
  localparam int BCR_FIXED = 14;
  localparam int BCR_ASYNC = 15;
  localparam logic [15:0] BCR_RST = 16'h9C07;
  localparam int RCR_PAR = 0;
  localparam int RCR_DPD = 4;
  localparam int RCR_TCR = 5;
  localparam logic [15:0] RCR_RST = 16'h0000;
  localparam int SEL_LSB = 18;
  localparam logic [1:0] SEL_RCR = 2'h0;
  localparam logic [1:0] SEL_DID = 2'h1;
  localparam logic [1:0] SEL_BCR = 2'h2;
  localparam logic [2:0] LEN4 = 3'h1;
  localparam logic [2:0] LEN8 = 3'h2;
  localparam logic [2:0] LEN16 = 3'h3;
  localparam logic [2:0] LEN32 = 3'h4;
  localparam logic [3:0] LAT_ONE = 4'h1;
  localparam logic [1:0] TEMP_MAX = 2'h3;
  localparam int CLK_NS = 20;
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  localparam int REF_CNT_W = 13;

  typedef enum logic [2:0] {PHB_IDLE, PHB_LAT, PHB_BURST, PHB_ROWEND, PHB_SLEEP} phb_state_t;

  function automatic logic [4:0] burst_mask(input logic [2:0] code);
    case (code)
      LEN4: burst_mask = 5'h03;
      LEN8: burst_mask = 5'h07;
      LEN16: burst_mask = 5'h0F;
      LEN32: burst_mask = 5'h1F;
      default: burst_mask = 5'h00;
    endcase
  endfunction

  function automatic logic [15:0] cfg_mux(input logic [1:0] sel, input logic [15:0] bus_config_reg,
                                          input logic [15:0] refresh_config_reg, input logic [15:0] id);
    case (sel)
      SEL_BCR: cfg_mux = bus_config_reg;
      SEL_DID: cfg_mux = id;
      default: cfg_mux = refresh_config_reg;
    endcase
  endfunction
endpackage

// File: core/phb_psram_if.sv
`timescale 1ns/1ps
module phb_psram_if
  import phb_pkg::*;
#(
  parameter int REF_BASE_CYC = REFRESH_CYC,
  parameter logic [15:0] DEVICE_ID = 16'h0A51 // Arbitrary identity value
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] pin_addr_i,
  input wire logic [DATA_W-1:0] pin_dq_i,
  output logic [DATA_W-1:0] pin_dq_o,
  output logic pin_dq_oe_o,
  input wire logic pin_clk_i,
  input wire logic pin_addr_valid_n_i,
  input wire logic pin_ce_n_i,
  input wire logic pin_oe_n_i,
  input wire logic pin_we_n_i,
  input wire logic pin_cfg_reg_select_i,
  input wire logic pin_low_byte_en_n_i,
  input wire logic pin_high_byte_en_n_i,
  output logic pin_wait_o,
  output logic pin_wait_oe_o,
  output logic arr_req_o,
  output logic arr_we_o,
  output logic [ADDR_W-1:0] arr_addr_o,
  output logic [DATA_W-1:0] arr_wdata_o,
  output logic [1:0] arr_be_o,
  input wire logic [DATA_W-1:0] arr_rdata_i,
  output logic ref_req_o,
  output logic [RROW_W-1:0] ref_row_o,
  input wire logic [1:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [31:0] av_writedata_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o
);
  localparam logic [REF_CNT_W-1:0] REF_BASE = REF_BASE_CYC[REF_CNT_W-1:0];
  localparam logic [RROW_W-1:0] RROW_FULL = '1;

  logic [PIN_W-1:0] sync1_reg, sync2_reg;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_dq;
  logic s_clk, s_adv_n, s_ce_n, s_oe_n, s_we_n, s_cre, s_lb_n, s_ub_n;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_reg <= {{(ADDR_W + DATA_W){1'b0}}, PIN_CTL_RST};
      sync2_reg <= {{(ADDR_W + DATA_W){1'b0}}, PIN_CTL_RST};
    end else begin
      sync1_reg <= {pin_addr_i, pin_dq_i, pin_clk_i, pin_addr_valid_n_i, pin_ce_n_i, pin_oe_n_i,
                    pin_we_n_i, pin_cfg_reg_select_i, pin_low_byte_en_n_i, pin_high_byte_en_n_i};
      sync2_reg <= sync1_reg;
    end
  end
  assign {s_addr, s_dq, s_clk, s_adv_n, s_ce_n, s_oe_n, s_we_n, s_cre, s_lb_n, s_ub_n} = sync2_reg;

  phb_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next, arr_addr_reg, arr_addr_next;
  logic [15:0] bcr_reg, bcr_next, rcr_reg, rcr_next;
  logic [DATA_W-1:0] dq_reg, dq_next, arr_wdata_reg, arr_wdata_next;
  logic [1:0] arr_be_reg, arr_be_next, temp_reg, temp_next;
  logic [3:0] lat_reg, lat_next;
  logic [5:0] cnt_reg, cnt_next;
  logic acc_we_reg, acc_we_next, acc_cfg_reg, acc_cfg_next;
  logic dq_oe_reg, dq_oe_next, wait_reg, wait_next, wait_oe_reg, wait_oe_next;
  logic arr_req_reg, arr_req_next, arr_we_reg, arr_we_next;
  logic clk_d_reg, clk_d_next, we_d_reg, we_d_next;
  logic [REF_CNT_W-1:0] ref_tmr_reg, ref_tmr_next, ref_ivl;
  logic ref_pend_reg, ref_pend_next, ref_req_reg, ref_req_next, ref_tick;
  logic [RROW_W-1:0] ref_row_reg, ref_row_next, row_mask;
  logic av_wr_reg, av_wr_next;
  logic [31:0] av_rd_reg, av_rd_next;
  logic s_ce, async_md, clk_rise, we_rise, capture, wrap_on, wpol, wait_asrt, rd_steal;
  logic [4:0] len_mask;
  logic [ADDR_W-1:0] len_ext;
  logic [2:0] lat_code;
  logic [1:0] temp_sel;

  assign s_ce = !s_ce_n;
  assign async_md = bcr_reg[BCR_ASYNC];
  assign clk_rise = s_clk && !clk_d_reg;
  assign we_rise = s_we_n && !we_d_reg;
  assign capture = s_ce && !async_md && clk_rise && !s_adv_n;
  assign len_mask = burst_mask(bcr_reg[BCR_LEN+:3]);
  assign len_ext = {{(ADDR_W - 5){1'b0}}, len_mask};
  assign wrap_on = bcr_reg[BCR_WRAP] && (len_mask != 5'h00);
  assign wpol = bcr_reg[BCR_WPOL];
  assign lat_code = bcr_reg[BCR_LAT+:3];
  // An explicit setting overrides the software-fed sensor reading
  assign temp_sel = (rcr_reg[RCR_TCR+:2] != 2'h0) ? rcr_reg[RCR_TCR+:2] : temp_reg;
  assign ref_ivl = REF_BASE << (TEMP_MAX - temp_sel);
  assign row_mask = RROW_FULL >> rcr_reg[RCR_PAR+:3];

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    bcr_next = bcr_reg;
    rcr_next = rcr_reg;
    acc_we_next = acc_we_reg;
    acc_cfg_next = acc_cfg_reg;
    lat_next = lat_reg;
    cnt_next = cnt_reg;
    dq_next = dq_reg;
    arr_req_next = 1'b0;
    arr_we_next = 1'b0;
    arr_addr_next = arr_addr_reg;
    arr_wdata_next = arr_wdata_reg;
    arr_be_next = arr_be_reg;
    wait_asrt = 1'b0;
    rd_steal = 1'b0;
    if (arr_req_reg && !arr_we_reg) begin
      dq_next = arr_rdata_i;
    end
    if (!s_ce) begin
      state_next = rcr_reg[RCR_DPD] ? PHB_SLEEP : PHB_IDLE;
    end else if (async_md) begin
      state_next = PHB_IDLE;
      wait_asrt = 1'b1;
      if (!s_adv_n) begin
        addr_next = s_addr;
      end
      if (we_rise) begin
        if (s_cre) begin
          if (addr_reg[SEL_LSB+:2] == SEL_BCR) bcr_next = addr_reg[15:0];
          else if (addr_reg[SEL_LSB+:2] == SEL_RCR) rcr_next = addr_reg[15:0];
        end else begin
          arr_req_next = 1'b1;
          arr_we_next = 1'b1;
          arr_addr_next = addr_reg;
          arr_wdata_next = s_dq;
          arr_be_next = {!s_ub_n, !s_lb_n};
        end
      end else if (s_we_n && !s_oe_n) begin
        if (s_cre) begin
          dq_next = cfg_mux(addr_next[SEL_LSB+:2], bcr_reg, rcr_reg, DEVICE_ID);
        end else begin
          arr_req_next = 1'b1;
          arr_addr_next = addr_next;
          rd_steal = 1'b1;
        end
      end
    end else if (capture) begin
      addr_next = s_addr;
      acc_we_next = !s_we_n;
      acc_cfg_next = s_cre;
      cnt_next = 6'h00;
      if (s_cre && !s_we_n) begin
        state_next = PHB_IDLE;
        if (s_addr[SEL_LSB+:2] == SEL_BCR) bcr_next = s_addr[15:0];
        else if (s_addr[SEL_LSB+:2] == SEL_RCR) rcr_next = s_addr[15:0];
      end else begin
        state_next = PHB_LAT;
        // A pending refresh costs a second latency period unless latency is fixed
        lat_next = (!bcr_reg[BCR_FIXED] && ref_pend_reg) ? {lat_code, 1'b0} : {1'b0, lat_code};
      end
    end else if (clk_rise) begin
      case (state_reg)
        PHB_LAT: begin
          if (lat_reg <= LAT_ONE) begin
            state_next = PHB_BURST;
            if (acc_cfg_reg) begin
              dq_next = cfg_mux(addr_reg[SEL_LSB+:2], bcr_reg, rcr_reg, DEVICE_ID);
            end else if (!acc_we_reg) begin
              arr_req_next = 1'b1;
              arr_addr_next = addr_reg;
            end
          end else begin
            lat_next = lat_reg - LAT_ONE;
          end
        end
        PHB_BURST: begin
          // Output enable high on a read suspends the burst without advancing
          if (acc_we_reg || !s_oe_n) begin
            if (acc_we_reg && !acc_cfg_reg) begin
              arr_req_next = 1'b1;
              arr_we_next = 1'b1;
              arr_addr_next = addr_reg;
              arr_wdata_next = s_dq;
              arr_be_next = {!s_ub_n, !s_lb_n};
            end
            cnt_next = cnt_reg + 6'h01;
            addr_next = wrap_on ? ((addr_reg & ~len_ext) | ((addr_reg + 1'b1) & len_ext))
                                : addr_reg + 1'b1;
            if (len_mask != 5'h00 && cnt_reg[4:0] == len_mask) begin
              state_next = PHB_IDLE;
            end else if (!wrap_on && (&addr_reg[ROW_W-1:0])) begin
              state_next = PHB_ROWEND;
            end else if (!acc_we_reg && !acc_cfg_reg) begin
              arr_req_next = 1'b1;
              arr_addr_next = addr_next;
            end
          end
        end
        PHB_ROWEND: begin
          state_next = PHB_BURST;
          if (!acc_we_reg && !acc_cfg_reg) begin
            arr_req_next = 1'b1;
            arr_addr_next = addr_reg;
          end
        end
        default: ;
      endcase
    end
    if (state_next == PHB_LAT || state_next == PHB_ROWEND) begin
      wait_asrt = 1'b1;
    end
    // Refresh timer reload and hidden refresh slot
    ref_tick = 1'b0;
    ref_tmr_next = ref_tmr_reg - 1'b1;
    ref_req_next = 1'b0;
    ref_row_next = ref_row_reg;
    if (state_next == PHB_SLEEP) begin
      ref_tmr_next = ref_ivl;
    end else if (ref_tmr_reg == '0) begin
      ref_tmr_next = ref_ivl;
      ref_tick = 1'b1;
    end
    ref_pend_next = (ref_tick || ref_pend_reg) && state_next != PHB_SLEEP;
    // A continuous async read gives up one sample so refresh never starves
    if (ref_pend_reg && state_next != PHB_SLEEP && (!arr_req_next || rd_steal)) begin
      arr_req_next = 1'b0;
      ref_req_next = 1'b1;
      ref_row_next = (ref_row_reg + 1'b1) & row_mask;
      ref_pend_next = ref_tick;
    end
    dq_oe_next = s_ce && !s_oe_n && s_we_n &&
                 (async_md || state_next == PHB_BURST || state_next == PHB_ROWEND);
    wait_next = wait_asrt ? wpol : !wpol;
    wait_oe_next = s_ce;
    clk_d_next = s_clk;
    we_d_next = s_we_n;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= PHB_IDLE;
      addr_reg <= '0;
      bcr_reg <= BCR_RST;
      rcr_reg <= RCR_RST;
      acc_we_reg <= 1'b0;
      acc_cfg_reg <= 1'b0;
      lat_reg <= '0;
      cnt_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      wait_reg <= 1'b0;
      wait_oe_reg <= 1'b0;
      arr_req_reg <= 1'b0;
      arr_we_reg <= 1'b0;
      arr_addr_reg <= '0;
      arr_wdata_reg <= '0;
      arr_be_reg <= '0;
      clk_d_reg <= 1'b0;
      we_d_reg <= 1'b1;
      ref_tmr_reg <= '0;
      ref_pend_reg <= 1'b0;
      ref_req_reg <= 1'b0;
      ref_row_reg <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      bcr_reg <= bcr_next;
      rcr_reg <= rcr_next;
      acc_we_reg <= acc_we_next;
      acc_cfg_reg <= acc_cfg_next;
      lat_reg <= lat_next;
      cnt_reg <= cnt_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      wait_reg <= wait_next;
      wait_oe_reg <= wait_oe_next;
      arr_req_reg <= arr_req_next;
      arr_we_reg <= arr_we_next;
      arr_addr_reg <= arr_addr_next;
      arr_wdata_reg <= arr_wdata_next;
      arr_be_reg <= arr_be_next;
      clk_d_reg <= clk_d_next;
      we_d_reg <= we_d_next;
      ref_tmr_reg <= ref_tmr_next;
      ref_pend_reg <= ref_pend_next;
      ref_req_reg <= ref_req_next;
      ref_row_reg <= ref_row_next;
    end
  end

  always_comb begin
    av_wr_next = !((av_read_i || av_write_i) && av_wr_reg);
    av_rd_next = av_rd_reg;
    temp_next = temp_reg;
    if (av_read_i && av_wr_reg) begin
      case (av_address_i)
        AV_STATUS: av_rd_next = {{29{1'b0}}, state_reg == PHB_SLEEP, !s_ce, ref_pend_reg};
        AV_TEMP: av_rd_next = {{30{1'b0}}, temp_reg};
        AV_BCR: av_rd_next = {{16{1'b0}}, bcr_reg};
        AV_RCR: av_rd_next = {{16{1'b0}}, rcr_reg};
        default: av_rd_next = '0;
      endcase
    end
    if (av_write_i && !av_wr_reg && av_address_i == AV_TEMP) begin
      temp_next = av_writedata_i[1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      av_wr_reg <= 1'b1;
      av_rd_reg <= '0;
      temp_reg <= TEMP_MAX;
    end else begin
      av_wr_reg <= av_wr_next;
      av_rd_reg <= av_rd_next;
      temp_reg <= temp_next;
    end
  end

  assign pin_dq_o = dq_reg;
  assign pin_dq_oe_o = dq_oe_reg;
  assign pin_wait_o = wait_reg;
  assign pin_wait_oe_o = wait_oe_reg;
  assign arr_req_o = arr_req_reg;
  assign arr_we_o = arr_we_reg;
  assign arr_addr_o = arr_addr_reg;
  assign arr_wdata_o = arr_wdata_reg;
  assign arr_be_o = arr_be_reg;
  assign ref_req_o = ref_req_reg;
  assign ref_row_o = ref_row_reg;
  assign av_readdata_o = av_rd_reg;
  assign av_waitrequest_o = av_wr_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sync_cap;
    capture && !s_cre;
  endsequence
  sequence s_cfg_wr_bcr;
    capture && s_cre && !s_we_n && s_addr[SEL_LSB+:2] == SEL_BCR;
  endsequence
  sequence s_async_wr;
    s_ce && async_md && we_rise && !s_cre;
  endsequence
  sequence s_wrap_step;
    state_reg == PHB_BURST && s_ce && !async_md && clk_rise && !capture && wrap_on &&
    (acc_we_reg || !s_oe_n);
  endsequence

  property p_dq_oe;
    pin_dq_oe_o |-> !$past(s_oe_n) && $past(s_we_n) && $past(s_ce);
  endproperty
  a_dq_oe: assert property (p_dq_oe) else $error("data driven without output enable");
  property p_wait_hiz;
    s_ce_n |=> !pin_wait_oe_o;
  endproperty
  a_wait_hiz: assert property (p_wait_hiz) else $error("wait driven while deselected");
  property p_sync_cap;
    s_sync_cap |=> state_reg == PHB_LAT && addr_reg == $past(s_addr);
  endproperty
  a_sync_cap: assert property (p_sync_cap) else $error("sync address not captured");
  property p_cfg_wr;
    s_cfg_wr_bcr |=> bcr_reg == $past(s_addr[15:0]) && state_reg == PHB_IDLE;
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("bus config not loaded from address");
  property p_sleep_quiet;
    state_reg == PHB_SLEEP |-> !ref_req_o && !ref_pend_reg;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("refresh during deep sleep");
  property p_standby;
    s_ce_n && !rcr_reg[RCR_DPD] |=> state_reg == PHB_IDLE;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");
  property p_par;
    ref_req_o |-> (ref_row_o & ~$past(row_mask)) == '0;
  endproperty
  a_par: assert property (p_par) else $error("refresh outside partial region");
  property p_async_wr;
    s_async_wr |=> arr_req_o && arr_we_o && arr_addr_o == $past(addr_reg);
  endproperty
  a_async_wr: assert property (p_async_wr) else $error("async write not issued");
  property p_wrap;
    s_wrap_step |=> (addr_reg & ~len_ext) == ($past(addr_reg) & ~$past(len_ext));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrapping burst left its block");
  property p_av;
    (av_read_i || av_write_i) && av_waitrequest_o |=> !av_waitrequest_o ##1 av_waitrequest_o;
  endproperty
  a_av: assert property (p_av) else $error("bus answer not one cycle");
endmodule

// File: testbench/phb_host_model.sv
`timescale 1ns/1ps
module phb_host_model
  import phb_pkg::*;
#(
  parameter int HALF = 5
) (
  input wire logic sys_clk_i,
  input wire logic [1:0] be_n_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic clk_o,
  output logic adv_n_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic cre_o,
  output logic lb_n_o,
  output logic ub_n_o
);
  initial begin
    addr_o = '0;
    dq_o = 16'h0000;
    rel();
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Released data lines show the inverse so stale values cannot pass a check
  task automatic rel();
    ce_n_o <= 1'b1;
    adv_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    we_n_o <= 1'b1;
    cre_o <= 1'b0;
    lb_n_o <= 1'b1;
    ub_n_o <= 1'b1;
    clk_o <= 1'b0;
    dq_o <= ~dq_o;
  endtask

  task automatic open_cyc(input logic c, input logic [ADDR_W-1:0] a, input logic wr);
    @(posedge sys_clk_i);
    ce_n_o <= 1'b0;
    adv_n_o <= 1'b0;
    cre_o <= c;
    addr_o <= a;
    oe_n_o <= wr;
    lb_n_o <= be_n_i[0];
    ub_n_o <= be_n_i[1];
  endtask

  task automatic async_wr(input logic c, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    open_cyc(c, a, 1'b1);
    dq_o <= d;
    cyc(HALF);
    we_n_o <= 1'b0;
    cyc(2 * HALF);
    we_n_o <= 1'b1;
    cyc(HALF);
    rel();
  endtask

  // Read stays open until the caller releases the bus
  task automatic async_rd(input logic c, input logic [ADDR_W-1:0] a, input int n);
    open_cyc(c, a, 1'b0);
    cyc(n);
  endtask

  task automatic sync_op(input logic c, input logic [ADDR_W-1:0] a, input logic wr,
                         input int n);
    open_cyc(c, a, wr);
    we_n_o <= !wr;
    cyc(HALF);
    clk_o <= 1'b1;
    cyc(HALF);
    clk_o <= 1'b0;
    adv_n_o <= 1'b1;
    repeat (n) begin
      cyc(HALF);
      clk_o <= 1'b1;
      cyc(HALF);
      clk_o <= 1'b0;
    end
    cyc(HALF);
    rel();
  endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import phb_pkg::*;
  logic sys_clk, rst, av_read, av_write, av_waitrequest;
  logic [1:0] av_address;
  logic [31:0] av_writedata, av_readdata, q;
  logic [ADDR_W-1:0] h_addr, arr_addr;
  logic [DATA_W-1:0] h_dq, d_dq, dq_w, arr_wdata, arr_rdata, lwd;
  logic h_clk, h_adv_n, h_ce_n, h_oe_n, h_we_n, h_cre, h_lb_n, h_ub_n;
  logic d_dq_oe, wait_lvl, wait_oe, arr_req, arr_we, ref_req;
  logic [1:0] arr_be, lbe, h_be_n;
  logic [RROW_W-1:0] ref_row;
  logic [ADDR_W-1:0] rq[$];
  int n_errors = 0;
  int comparisons = 0;
  int nref = 0;

  assign dq_w = d_dq_oe ? d_dq : h_dq;

  phb_psram_if #(.REF_BASE_CYC(20), .DEVICE_ID(16'h1234)) dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .pin_addr_i(h_addr), .pin_dq_i(dq_w),
    .pin_dq_o(d_dq), .pin_dq_oe_o(d_dq_oe), .pin_clk_i(h_clk),
    .pin_addr_valid_n_i(h_adv_n), .pin_ce_n_i(h_ce_n), .pin_oe_n_i(h_oe_n),
    .pin_we_n_i(h_we_n), .pin_cfg_reg_select_i(h_cre), .pin_low_byte_en_n_i(h_lb_n),
    .pin_high_byte_en_n_i(h_ub_n), .pin_wait_o(wait_lvl), .pin_wait_oe_o(wait_oe),
    .arr_req_o(arr_req), .arr_we_o(arr_we), .arr_addr_o(arr_addr),
    .arr_wdata_o(arr_wdata), .arr_be_o(arr_be), .arr_rdata_i(arr_rdata),
    .ref_req_o(ref_req), .ref_row_o(ref_row), .av_address_i(av_address),
    .av_read_i(av_read), .av_write_i(av_write), .av_writedata_i(av_writedata),
    .av_readdata_o(av_readdata), .av_waitrequest_o(av_waitrequest));

  phb_host_model ctl (
    .sys_clk_i(sys_clk), .be_n_i(h_be_n), .addr_o(h_addr), .dq_o(h_dq), .clk_o(h_clk),
    .adv_n_o(h_adv_n), .ce_n_o(h_ce_n), .oe_n_o(h_oe_n), .we_n_o(h_we_n),
    .cre_o(h_cre), .lb_n_o(h_lb_n), .ub_n_o(h_ub_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Array stand-in: read data follows the address within the request cycle
  assign arr_rdata = arr_addr[15:0] ^ 16'h5A5A;

  always @(posedge sys_clk) begin
    if (arr_req) begin
      rq.push_back(arr_addr);
      lwd <= arr_wdata;
      lbe <= arr_be;
    end
    if (ref_req) nref++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    av_address <= a;
    av_write <= wr;
    av_read <= !wr;
    av_writedata <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (av_waitrequest !== 1'b0 && k < 50);
    q = av_readdata;
    chk(k < 50, 1, "bus answer");
    av_read <= 1'b0;
    av_write <= 1'b0;
  endtask

  task automatic t_regs();
    av(0, 2'h2, 0); chk(q, {16'h0, BCR_RST}, "bcr reset");
    av(0, 2'h3, 0); chk(q, {16'h0, RCR_RST}, "rcr reset");
    av(1, 2'h2, 32'h1234);
    av(0, 2'h2, 0); chk(q, {16'h0, BCR_RST}, "bcr read only");
    av(1, 2'h1, 32'h1);
    av(0, 2'h1, 0); chk(q, 32'h1, "temp write");
    av(1, 2'h1, 32'h3);
    $display("done regs");
  endtask

  task automatic t_async();
    rq.delete();
    ctl.async_wr(0, 22'h2ABCDE, 16'hC3A5);
    ctl.cyc(6);
    chk(rq.size(), 1, "write count");
    if (rq.size() > 0) chk(rq[0], 22'h2ABCDE, "write addr");
    chk(lwd, 16'hC3A5, "write data");
    chk(lbe, 2'b11, "byte en");
    h_be_n <= 2'b01;
    ctl.async_wr(0, 22'h155555, 16'h3C5A);
    ctl.cyc(6);
    chk(lbe, 2'b10, "upper byte only");
    chk(lwd, 16'h3C5A, "write data 2");
    h_be_n <= 2'b00;
    ctl.async_rd(0, 22'h3FFFFF, 16);
    chk(d_dq_oe, 1, "dq drive");
    chk(d_dq, 16'hA5A5, "read data");
    chk({wait_oe, wait_lvl}, 2'b11, "wait async");
    ctl.rel();
    ctl.cyc(6);
    chk(d_dq_oe, 0, "dq off");
    chk(wait_oe, 0, "wait float");
    $display("done async");
  endtask

  task automatic t_cfgrd();
    ctl.async_rd(1, 22'h080000, 16);
    chk(d_dq, BCR_RST, "cfg read bcr");
    ctl.rel();
    ctl.async_rd(1, 22'h040000, 16);
    chk(d_dq, 16'h1234, "cfg read id");
    ctl.rel();
    ctl.cyc(4);
    $display("done cfg read");
  endtask

  task automatic t_power();
    int n0;
    ctl.async_wr(1, 22'h000010, 16'h0);
    ctl.cyc(4);
    av(0, 2'h3, 0); chk(q, 32'h10, "rcr from addr");
    av(0, 2'h0, 0); chk(q[2:1], 2'b11, "deep sleep");
    n0 = nref;
    ctl.cyc(200);
    chk(nref - n0, 0, "no refresh asleep");
    ctl.async_rd(0, 0, 8);
    ctl.rel();
    ctl.async_wr(1, 22'h000000, 16'h0);
    ctl.cyc(4);
    av(0, 2'h0, 0); chk(q[2:1], 2'b01, "standby");
    rq.delete();
    n0 = nref;
    ctl.cyc(400);
    chk(nref - n0 >= 19 && nref - n0 <= 21, 1, "refresh rate hot");
    av(1, 2'h1, 0);
    n0 = nref;
    ctl.cyc(640);
    chk(nref - n0 >= 3 && nref - n0 <= 5, 1, "refresh rate cold");
    av(1, 2'h1, 32'h3);
    chk(rq.size(), 0, "idle in standby");
    $display("done power");
  endtask

  // Shift of 7 leaves 256 rows, so the row counter must wrap once in this span
  task automatic t_partial();
    logic [RROW_W-1:0] prev;
    int wraps;
    wraps = 0;
    ctl.async_wr(1, 22'h000007, 16'h0);
    prev = ref_row;
    repeat (6000) begin
      @(posedge sys_clk);
      if (ref_req) begin
        if (ref_row < prev) wraps++;
        prev = ref_row;
      end
    end
    chk(wraps, 1, "partial wrap");
    chk(prev >> 8, 0, "partial rows");
    ctl.async_wr(1, 22'h000000, 16'h0);
    ctl.cyc(4);
    $display("done partial");
  endtask

  task automatic burst(input logic [ADDR_W-1:0] a, input logic [1:0] st);
    rq.delete();
    ctl.sync_op(0, a, 0, 10);
    ctl.cyc(8);
    chk(rq.size(), 4, "burst length");
    for (int i = 0; i < 4 && i < rq.size(); i++) begin
      chk(rq[i], {a[21:2], 2'(st + i)}, "burst order");
    end
  endtask

  task automatic t_sync();
    ctl.async_wr(1, 22'h085C09, 16'h0);
    ctl.cyc(4);
    av(0, 2'h2, 0); chk(q, 32'h5C09, "bcr load");
    burst(22'h001006, 2'h2);
    ctl.sync_op(1, 22'h085C01, 1, 0);
    ctl.cyc(4);
    av(0, 2'h2, 0); chk(q, 32'h5C01, "bcr sync load");
    burst(22'h001004, 2'h0);
    ctl.sync_op(1, 22'h085C07, 1, 0);
    rq.delete();
    ctl.sync_op(0, 22'h00107E, 0, 8);
    ctl.cyc(8);
    chk(rq.size(), 5, "row end slot");
    for (int i = 0; i < 5 && i < rq.size(); i++) begin
      chk(rq[i], 22'h00107E + i, "row end order");
    end
    chk(d_dq, 16'h1082 ^ 16'h5A5A, "burst data");
    $display("done sync");
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("[FAIL] %0t watchdog", $time);
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    av_read = 1'b0;
    av_write = 1'b0;
    av_address = 2'h0;
    av_writedata = 32'h0;
    h_be_n = 2'b00;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    ctl.cyc(4);
    t_regs();
    t_async();
    t_cfgrd();
    t_power();
    t_partial();
    t_sync();
    end_of_test();
  end
endmodule
